// ===== rtl/msq_pkg.sv
package msq_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned AVG_SAMPLES   = 16;
  localparam int unsigned T_INT_AVG_US  = 25920;
  localparam int unsigned T_EXT_AVG_US  = 16800;
  localparam int unsigned T_FAST_AVG_US = 712;
  // per-sample period: averaged total split over the sixteen samples, rounded down
  localparam int unsigned INT_SAMPLE_CYC  = T_INT_AVG_US * 1000 / CLK_PERIOD_NS / AVG_SAMPLES;
  localparam int unsigned EXT_SAMPLE_CYC  = T_EXT_AVG_US * 1000 / CLK_PERIOD_NS / AVG_SAMPLES;
  localparam int unsigned FAST_SAMPLE_CYC = T_FAST_AVG_US * 1000 / CLK_PERIOD_NS / AVG_SAMPLES;
  localparam int unsigned TMR_W           = 18;
  localparam logic [3:0]  LAST_SMP        = 4'hf;

  // ----------------------------------------
  // register indexes (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [5:0] IDX_LSB_A    = 6'h03;
  localparam logic [5:0] IDX_LSB_B    = 6'h04;
  localparam logic [5:0] IDX_MSB_BASE = 6'h06;
  localparam logic [5:0] IDX_MSB_LAST = 6'h0b;
  localparam logic [5:0] IDX_CFG1     = 6'h18;
  localparam logic [5:0] IDX_CFG2     = 6'h19;
  localparam logic [5:0] IDX_CFG3     = 6'h1a;
  localparam logic [5:0] IDX_STAT     = 6'h1d;
  localparam logic [5:0] IDX_OFFS     = 6'h1e;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int unsigned CFG1_EN_BIT     = 0;
  localparam int unsigned CFG1_AIN_BIT    = 2;
  localparam int unsigned CFG2_CH_LSB     = 0;
  localparam int unsigned CFG2_SINGLE_BIT = 4;
  localparam int unsigned CFG2_NOAVG_BIT  = 5;
  localparam int unsigned CFG3_FAST_BIT   = 0;
  localparam int unsigned CFG3_ADCREF_BIT = 1;
  localparam int unsigned CFG3_DACINT_BIT = 4;
  localparam logic [7:0]  CFG1_RST        = 8'h00;
  localparam logic [7:0]  CFG2_RST        = 8'h00;
  localparam logic [7:0]  CFG3_RST        = 8'h00;
  localparam logic [7:0]  OFFS_RST        = 8'h00;
  localparam int unsigned NUM_CH          = 6;

  typedef enum logic [2:0] {
    CH_VDD  = 3'h0,
    CH_TINT = 3'h1,
    CH_EXT  = 3'h2,
    CH_ANALOG_INPUT_TWO = 3'h3,
    CH_ANALOG_INPUT_THREE = 3'h4,
    CH_ANALOG_INPUT_FOUR = 3'h5
  } msq_ch_e;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_RUN   = 2'b01,
    S_STORE = 2'b11
  } msq_st_e;

endpackage

// ===== rtl/msq_tmr.sv
`timescale 1ns/1ps
`default_nettype none
module msq_tmr (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     start,
  input  wire logic [msq_pkg::TMR_W-1:0] len,
  output logic                          done,
  output logic                          hi_half
);
  import msq_pkg::*;

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] half_q;
  logic             busy_q;

  assign done    = busy_q & (cnt_q == {{(TMR_W-1){1'b0}}, 1'b1});
  assign hi_half = busy_q & (cnt_q <= half_q);

  // restart always reloads, so a stale count never leaks into a new sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      half_q <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q  <= len;
      half_q <= len >> 1;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - 1'b1;
      busy_q <= !done;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/msq_acc.sv
`timescale 1ns/1ps
`default_nettype none
module msq_acc (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       add,
  input  wire logic       is_signed,
  input  wire logic       avg16,
  input  wire logic [9:0] sample,
  output logic      [9:0] result
);

  logic [13:0] sum_q;
  wire  [13:0] ext_smp = {{4{is_signed & sample[9]}}, sample};

  // sixteen 10-bit codes fit 14 bits signed or unsigned; shift by four averages
  assign result = avg16 ? sum_q[13:4] : sum_q[9:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_q <= '0;
    end else if (clear) begin
      sum_q <= '0;
    end else if (add) begin
      sum_q <= sum_q + ext_smp;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/msq_top.sv
`timescale 1ns/1ps
`default_nettype none
module msq_top #(
  parameter int unsigned INT_SAMPLE_CYC  = msq_pkg::INT_SAMPLE_CYC,
  parameter int unsigned EXT_SAMPLE_CYC  = msq_pkg::EXT_SAMPLE_CYC,
  parameter int unsigned FAST_SAMPLE_CYC = msq_pkg::FAST_SAMPLE_CYC
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [9:0]  ADC_DATA,
  output logic      [2:0]  ADC_CHAN,
  output logic             ADC_SAMPLE,
  output logic             ADC_RESET,
  output logic             ADC_FAST_CLK,
  output logic             DIODE_FILTER_OFF,
  output logic             DIODE_HI_CUR,
  output logic             PINS_AS_AIN,
  output logic             ADC_REF_EXT,
  output logic             DAC_REF_EXT,
  output logic             REF_AMP_EN
);
  import msq_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [7:0]  cfg1_q;
  logic [7:0]  cfg2_q;
  logic [7:0]  cfg3_q;
  logic [7:0]  offs_q;
  logic [31:0] prdata_q;
  logic [1:0]  lock_q;
  logic [9:0]  res_q [NUM_CH];
  logic [7:0]  msb_q [NUM_CH];
  msq_st_e     st_q;
  msq_st_e     st_d;
  msq_ch_e     cur_q;
  logic [3:0]  nsmp_q;
  logic        avg16_q;
  logic        fast_q;
  logic        ain_q;
  logic        single_q;
  logic        smp_q;
  logic        diode_q;
  logic        start;
  logic        tmr_done;
  logic        tmr_hi;
  logic [9:0]  acc_res;
  logic [7:0]  rd_mux;

  function automatic logic is_msb(input logic [5:0] i);
    is_msb = (i >= IDX_MSB_BASE) && (i <= IDX_MSB_LAST);
  endfunction

  function automatic logic is_mapped(input logic [5:0] i);
    is_mapped = is_msb(i) || (i == IDX_LSB_A) || (i == IDX_LSB_B) || (i == IDX_CFG1)
             || (i == IDX_CFG2) || (i == IDX_CFG3) || (i == IDX_STAT) || (i == IDX_OFFS);
  endfunction

  function automatic msq_ch_e rr_next(input msq_ch_e c, input logic ain);
    unique case (c)
      CH_VDD:  rr_next = CH_TINT;
      CH_TINT: rr_next = CH_EXT;
      CH_EXT:  rr_next = ain ? CH_ANALOG_INPUT_TWO : CH_ANALOG_INPUT_THREE;
      CH_ANALOG_INPUT_TWO: rr_next = CH_ANALOG_INPUT_THREE;
      CH_ANALOG_INPUT_THREE: rr_next = CH_ANALOG_INPUT_FOUR;
      default: rr_next = CH_VDD;
    endcase
  endfunction

  function automatic msq_ch_e sel_ch(input logic [2:0] f, input logic ain);
    if (f == 3'h3 && !ain) begin
      sel_ch = CH_EXT;
    end else if (f > 3'h5) begin
      sel_ch = CH_VDD;
    end else begin
      sel_ch = msq_ch_e'(f);
    end
  endfunction

  function automatic logic [TMR_W-1:0] smp_len(input msq_ch_e c, input logic ain,
                                                input logic fast);
    if (c == CH_TINT) begin
      smp_len = TMR_W'(INT_SAMPLE_CYC);
    end else if (c == CH_EXT && !ain && !fast) begin
      smp_len = TMR_W'(EXT_SAMPLE_CYC);
    end else begin
      smp_len = TMR_W'(FAST_SAMPLE_CYC);
    end
  endfunction

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire [5:0] idx     = PADDR[7:2];
  wire       mapped  = (PADDR[1:0] == 2'b00) && is_mapped(idx);
  wire       setup   = PSEL & !PENABLE;
  wire       access  = PSEL & PENABLE;
  wire       wr      = access & PWRITE & mapped;
  wire       rd      = access & !PWRITE & mapped;
  wire       rd_lsb_a = rd & (idx == IDX_LSB_A);
  wire       rd_lsb_b = rd & (idx == IDX_LSB_B);
  wire       rd_msb  = rd & is_msb(idx);
  wire [2:0] msb_sel = 3'(idx - IDX_MSB_BASE);

  assign PREADY  = 1'b1;
  assign PSLVERR = access & !mapped;
  assign PRDATA  = prdata_q;

  always_comb begin
    rd_mux = 8'h00;
    if (is_msb(idx)) begin
      rd_mux = msb_q[msb_sel];
    end else begin
      unique case (idx)
        IDX_LSB_A: rd_mux = {4'h0, res_q[CH_TINT][1:0], res_q[CH_VDD][1:0]};
        IDX_LSB_B: rd_mux = {res_q[CH_ANALOG_INPUT_FOUR][1:0], res_q[CH_ANALOG_INPUT_THREE][1:0],
                             res_q[CH_ANALOG_INPUT_TWO][1:0], res_q[CH_EXT][1:0]};
        IDX_CFG1:  rd_mux = cfg1_q;
        IDX_CFG2:  rd_mux = cfg2_q;
        IDX_CFG3:  rd_mux = cfg3_q;
        IDX_STAT:  rd_mux = {2'b00, |lock_q, single_q, st_q == S_RUN, cur_q};
        IDX_OFFS:  rd_mux = offs_q;
        default:   rd_mux = 8'h00;
      endcase
    end
  end

  // read data is staged during the setup cycle so it can come from a flop
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= (mapped && !PWRITE) ? {24'h0, rd_mux} : 32'h0;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // reset values
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg1_q <= CFG1_RST;
      cfg2_q <= CFG2_RST;
      cfg3_q <= CFG3_RST;
      offs_q <= OFFS_RST;
    end else if (wr) begin
      if (idx == IDX_CFG1) cfg1_q <= PWDATA[7:0];
      if (idx == IDX_CFG2) cfg2_q <= PWDATA[7:0];
      if (idx == IDX_CFG3) cfg3_q <= PWDATA[7:0];
      if (idx == IDX_OFFS) offs_q <= PWDATA[7:0];
    end
  end

  wire       en       = cfg1_q[CFG1_EN_BIT];
  wire       halt     = PSEL;
  wire       single_c = cfg2_q[CFG2_SINGLE_BIT];
  wire       ain_c    = cfg1_q[CFG1_AIN_BIT];
  wire       fast_c   = cfg3_q[CFG3_FAST_BIT];
  wire       run      = (st_q == S_RUN);
  wire       last     = avg16_q ? (nsmp_q == LAST_SMP) : 1'b1;
  wire       take     = run & tmr_done & en & !halt;
  wire       store    = (st_q == S_STORE);
  wire       ext_diod = (cur_q == CH_EXT) & !ain_q;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    st_d  = st_q;
    start = 1'b0;
    unique case (st_q)
      // start or resume once enabled and bus is quiet
      S_IDLE: begin
        if (en && !halt) begin
          st_d  = S_RUN;
          start = 1'b1;
        end
      end
      S_RUN: begin
        if (!en || halt) begin
          st_d = S_IDLE;
        end else if (tmr_done && last) begin
          st_d = S_STORE;
        end
      end
      S_STORE: begin
        if (en && !halt) begin
          st_d  = S_RUN;
          start = 1'b1;
        end else begin
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // selection sampled only at a start
  wire msq_ch_e ch_next = single_c ? sel_ch(cfg2_q[2:0], ain_c)
                        : (store && !single_q) ? rr_next(cur_q, ain_c) : cur_q;
  wire [TMR_W-1:0] len = start ? smp_len(ch_next, ain_c, fast_c) : smp_len(cur_q, ain_q, fast_q);

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= S_IDLE;
      cur_q    <= CH_VDD;
      nsmp_q   <= '0;
      avg16_q  <= 1'b1;
      fast_q   <= 1'b0;
      ain_q    <= 1'b0;
      single_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (start) begin
        cur_q    <= ch_next;
        nsmp_q   <= '0;
        avg16_q  <= !cfg2_q[CFG2_NOAVG_BIT];
        fast_q   <= fast_c;
        ain_q    <= ain_c;
        single_q <= single_c;
      end else if (!en) begin
        // disabled scan restarts from the supply channel
        cur_q <= CH_VDD;
      end else if (take) begin
        nsmp_q <= nsmp_q + 1'b1;
      end
    end
  end

  msq_tmr u_tmr (
    .clk     (CORE_CLK),
    .rst_n   (rst_n),
    .start   (start | (take & !last)),
    .len     (len),
    .done    (tmr_done),
    .hi_half (tmr_hi)
  );

  msq_acc u_acc (
    .clk       (CORE_CLK),
    .rst_n     (rst_n),
    .clear     (start),
    .add       (take),
    .is_signed ((cur_q == CH_TINT) | ext_diod),
    .avg16     (avg16_q),
    .sample    (ADC_DATA),
    .result    (acc_res)
  );

  // ----------------------------------------
  // results and high-byte lock
  // ----------------------------------------
  // offset added before storing; code lsb stays 0.25 degree
  wire [9:0] tint_val = acc_res + {{2{offs_q[7]}}, offs_q};
  // supply code passes through unscaled; the front end divides by 7/2.25
  wire [9:0] store_val = (cur_q == CH_TINT) ? tint_val : acc_res;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 2'b00;
      for (int i = 0; i < NUM_CH; i++) begin
        res_q[i] <= '0;
        msb_q[i] <= '0;
      end
    end else begin
      // low read locks, any high read releases
      // each low register locks only its own channels' high bytes
      lock_q <= rd_msb ? 2'b00 : (lock_q | {rd_lsb_b, rd_lsb_a});
      if (store) begin
        res_q[cur_q] <= store_val;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (!(i < 2 ? lock_q[0] : lock_q[1])) begin
          msb_q[i] <= res_q[i][9:2];
        end
      end
    end
  end

  // ----------------------------------------
  // analog side controls
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      smp_q   <= 1'b0;
      diode_q <= 1'b0;
    end else begin
      smp_q   <= take;
      // base current first half, n-times second
      diode_q <= run & ext_diod & tmr_hi;
    end
  end

  assign ADC_CHAN         = cur_q;
  assign ADC_SAMPLE       = smp_q;
  assign ADC_RESET        = !run;
  assign ADC_FAST_CLK     = run & ext_diod & fast_q;
  assign DIODE_FILTER_OFF = fast_c;
  assign DIODE_HI_CUR     = diode_q;
  assign PINS_AS_AIN      = ain_c;
  // forced internal for supply and temperatures
  assign ADC_REF_EXT      = cfg3_q[CFG3_ADCREF_BIT] & (cur_q > CH_EXT || (cur_q == CH_EXT && ain_q));
  assign DAC_REF_EXT      = !cfg3_q[CFG3_DACINT_BIT];
  assign REF_AMP_EN       = en;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n);

  no_sample_off_a: assert property (!en |=> !ADC_SAMPLE)
    else $error("sample while disabled");
  start_on_en_a: assert property ($rose(en) && !halt && st_q == S_IDLE |=> run)
    else $error("enable did not start");
  rr_order_a: assert property (store && !single_q && cur_q == CH_VDD && en && !halt
                               |=> cur_q == CH_TINT)
    else $error("scan order broken");
  back2back_a: assert property (store && single_q && en && !halt |=> run)
    else $error("gap in single mode");
  halt_abort_a: assert property (run && halt |=> st_q == S_IDLE ##1 !ADC_SAMPLE)
    else $error("access did not abort");
  avg_count_a: assert property ($rose(store) && avg16_q |-> $past(nsmp_q) == LAST_SMP)
    else $error("average not sixteen");
  int_ref_a: assert property (cur_q <= CH_TINT |-> !ADC_REF_EXT)
    else $error("external ref on internal channel");
  amp_off_a: assert property ($fell(en) |-> !REF_AMP_EN ##1 !run)
    else $error("amplifier stayed on");
  offset_add_a: assert property (store && cur_q == CH_TINT
                                 |=> res_q[CH_TINT] == $past(acc_res) + $past({{2{offs_q[7]}}, offs_q}))
    else $error("offset not applied");
  lock_hold_a: assert property (lock_q[0] && !rd_msb |=> $stable(msb_q[0]) && $stable(msb_q[1]))
    else $error("locked high byte moved");

endmodule
`default_nettype wire

// ===== test/msq_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// converter front end stand-in
// ----------------------------------------
module msq_adc_model (
  input  wire logic       clk,
  input  wire logic [2:0] chan,
  input  wire logic       adc_rst,
  input  wire logic [9:0] codes [6],
  output logic      [9:0] data
);
  logic tog = 1'b0;
  always @(posedge clk) tog <= ~tog;
  // held in reset there is no valid code, so show a moving pattern, never the last one
  assign data = adc_rst ? (tog ? 10'h2aa : 10'h155) : (chan < 3'h6 ? codes[chan] : 10'h3c3);
endmodule
`default_nettype wire

// ===== test/test_measurement_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_measurement_sequencer;
  import msq_pkg::*;
  localparam int unsigned INT_C  = 20;
  localparam int unsigned EXT_C  = 12;
  localparam int unsigned FAST_C = 6;
  logic        CORE_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rdata;
  logic [9:0]  ADC_DATA, old;
  logic [2:0]  ADC_CHAN, st_ch;
  logic        ADC_SAMPLE, ADC_RESET, ADC_FAST_CLK, DIODE_FILTER_OFF, DIODE_HI_CUR;
  logic        PINS_AS_AIN, ADC_REF_EXT, DAC_REF_EXT, REF_AMP_EN, rerr;
  logic [9:0]  codes [6];
  logic [2:0]  seq [$];
  logic [2:0]  rr_d [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h0};
  logic [7:0]  rst_v [3] = '{CFG1_RST, CFG2_RST, CFG3_RST};
  int          err_total, comparisons, stores, smp_n, smp_tot, last_cnt, last_t, cyc, run_len, i, n;
  logic        have_last, rst_d, psel_seen, ain_q, fast_q, ref_q, hi_seen;

  msq_top #(.INT_SAMPLE_CYC(INT_C), .EXT_SAMPLE_CYC(EXT_C), .FAST_SAMPLE_CYC(FAST_C)) dut_u (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ADC_DATA(ADC_DATA), .ADC_CHAN(ADC_CHAN), .ADC_SAMPLE(ADC_SAMPLE), .ADC_RESET(ADC_RESET),
    .ADC_FAST_CLK(ADC_FAST_CLK), .DIODE_FILTER_OFF(DIODE_FILTER_OFF),
    .DIODE_HI_CUR(DIODE_HI_CUR), .PINS_AS_AIN(PINS_AS_AIN), .ADC_REF_EXT(ADC_REF_EXT),
    .DAC_REF_EXT(DAC_REF_EXT), .REF_AMP_EN(REF_AMP_EN));
  msq_adc_model adc_u (.clk(CORE_CLK), .chan(ADC_CHAN), .adc_rst(ADC_RESET), .codes(codes),
    .data(ADC_DATA));

  // ----------------------------------------
  // compare and closing tasks
  // ----------------------------------------
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_int(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      err_total++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic fail();
    err_total++;
    $display("Error at %0t: wait ran out", $time);
    close_out();
  endtask

  // ----------------------------------------
  // bus and wait tasks
  // ----------------------------------------
  // an idle edge first, so a strobe is never lowered and raised in one step
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    int k;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= {24'h0, wd};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge CORE_CLK);
      if (PREADY === 1'b1) break;
    end
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k == 50) fail();
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
    if (idx == IDX_CFG1) ain_q = wd[CFG1_AIN_BIT];
    if (idx == IDX_CFG3) fast_q = wd[CFG3_FAST_BIT];
    if (idx == IDX_CFG3) ref_q = wd[CFG3_ADCREF_BIT];
    @(posedge CORE_CLK);
    seq.delete();
  endtask
  task automatic wait_store(input int cnt);
    int t0;
    int k;
    t0 = stores;
    for (k = 0; k < 4000 * cnt && stores < t0 + cnt; k++) @(posedge CORE_CLK);
    if (stores < t0 + cnt) fail();
  endtask
  task automatic chk_res(input int ch, input logic [9:0] e);
    logic [7:0] lsb;
    apb(1'b0, IDX_MSB_BASE + 6'(ch), 8'h00);
    chk_reg(rdata[7:0], e[9:2]);
    apb(1'b0, ch < 2 ? IDX_LSB_A : IDX_LSB_B, 8'h00);
    lsb = rdata[7:0] >> (2 * (ch < 2 ? ch : ch - 2));
    chk_reg({6'h0, lsb[1:0]}, {6'h0, e[1:0]});
    // reading the low part locked the high parts: release them again
    apb(1'b0, IDX_MSB_BASE, 8'h00);
  endtask
  function automatic int gap_of(input logic [2:0] ch);
    if (ch == 3'h1) return INT_C;
    if (ch == 3'h2 && !ain_q && !fast_q) return EXT_C;
    return FAST_C;
  endfunction

  // ----------------------------------------
  // converter side monitor
  // ----------------------------------------
  // sampled mid-cycle so flop outputs have settled
  always @(negedge CORE_CLK) begin
    cyc++;
    if (PSEL === 1'b1) psel_seen = 1'b1;
    if (DIODE_HI_CUR === 1'b1) hi_seen = 1'b1;
    if (ADC_SAMPLE === 1'b1) smp_n++;
    if (ADC_SAMPLE === 1'b1) smp_tot++;
    if (ADC_SAMPLE === 1'b1 && ADC_RESET === 1'b0) begin
      if (have_last) chk_int(cyc - last_t, gap_of(ADC_CHAN));
      chk_bit(ADC_REF_EXT, ref_q && (ADC_CHAN > 3'h2 || (ADC_CHAN == 3'h2 && ain_q)));
      have_last = 1'b1;
      last_t = cyc;
    end
    if (ADC_RESET === 1'b0 && ADC_CHAN == 3'h2 && !ain_q) chk_bit(ADC_FAST_CLK, fast_q);
    if (ADC_RESET === 1'b1 && !rst_d) st_ch = ADC_CHAN;
    if (ADC_RESET === 1'b1 && !rst_d) have_last = 1'b0;
    if (ADC_RESET === 1'b1) run_len++;
    if (ADC_RESET === 1'b0 && rst_d) begin
      // a gap with no bus traffic ends a completed conversion
      if (!psel_seen) begin
        chk_int(run_len, 1);
        seq.push_back(st_ch);
        last_cnt = smp_n;
        stores++;
      end
      smp_n = 0;
      run_len = 0;
      psel_seen = 1'b0;
    end
    rst_d = (ADC_RESET === 1'b1);
  end

  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    codes = '{10'h2db, 10'h064, 10'h0c8, 10'h155, 10'h200, 10'h3b6};
    {err_total, comparisons, stores, smp_n, smp_tot, last_cnt, last_t, cyc, run_len} = '0;
    {have_last, psel_seen, ain_q, fast_q, ref_q, hi_seen} = '0;
    rst_d = 1'b1;
    repeat (20) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    chk_bit(REF_AMP_EN, 1'b0);
    chk_bit(DAC_REF_EXT, 1'b1);
    for (i = 0; i < 3; i++) begin
      apb(1'b0, IDX_CFG1 + 6'(i), 8'h00);
      chk_reg(rdata[7:0], rst_v[i]);
    end
    repeat (50) @(posedge CORE_CLK);
    chk_int(smp_tot, 0);
    apb(1'b0, 6'h02, 8'h00);
    chk_bit(rerr, 1'b1);
    chk_reg(rdata[7:0], 8'h00);
    wr(IDX_CFG3, 8'h12);
    chk_bit(DAC_REF_EXT, 1'b0);
    wr(IDX_CFG1, 8'h01);
    chk_bit(REF_AMP_EN, 1'b1);
    wait_store(6);
    for (i = 0; i < 6; i++) chk_reg({5'h0, seq[i]}, {5'h0, rr_d[i]});
    for (i = 0; i < 6; i++) chk_res(i, i == 3 ? 10'h000 : codes[i]);
    wr(IDX_CFG1, 8'h04);
    wr(IDX_CFG1, 8'h05);
    chk_bit(PINS_AS_AIN, 1'b1);
    wait_store(6);
    for (i = 0; i < 6; i++) chk_reg({5'h0, seq[i]}, 8'(i));
    for (i = 0; i < 6; i++) chk_res(i, codes[i]);
    wr(IDX_OFFS, 8'h80);
    wait_store(6);
    // offset of -128, sign extended to the code width
    chk_res(1, codes[1] + 10'h380);
    for (i = 0; i < 6; i++) begin
      wr(IDX_CFG2, 8'h10 | 8'(i));
      wait_store(2);
      chk_reg({5'h0, seq[0]}, 8'(i));
      chk_reg({5'h0, seq[1]}, 8'(i));
      chk_int(last_cnt, AVG_SAMPLES);
    end
    wr(IDX_CFG2, 8'h30);
    wait_store(3);
    chk_int(last_cnt, 1);
    wr(IDX_CFG2, 8'h10);
    wait_store(1);
    for (n = 0; n < 200 && smp_n < 5; n++) @(posedge CORE_CLK);
    apb(1'b0, IDX_STAT, 8'h00);
    chk_bit(ADC_RESET, 1'b1);
    wait_store(1);
    chk_int(last_cnt, AVG_SAMPLES);
    chk_reg({5'h0, seq[seq.size() - 1]}, 8'h00);
    apb(1'b0, IDX_LSB_A, 8'h00);
    old = codes[0];
    codes[0] <= 10'h16e;
    wait_store(2);
    apb(1'b0, IDX_MSB_BASE, 8'h00);
    chk_reg(rdata[7:0], old[9:2]);
    wait_store(2);
    apb(1'b0, IDX_MSB_BASE, 8'h00);
    chk_reg(rdata[7:0], codes[0][9:2]);
    wr(IDX_CFG1, 8'h01);
    wr(IDX_CFG3, 8'h01);
    wr(IDX_CFG2, 8'h12);
    chk_bit(DIODE_FILTER_OFF, 1'b1);
    hi_seen = 1'b0;
    wait_store(2);
    chk_bit(hi_seen, 1'b1);
    wr(IDX_CFG1, 8'h00);
    chk_bit(REF_AMP_EN, 1'b0);
    n = smp_tot;
    repeat (100) @(posedge CORE_CLK);
    chk_int(smp_tot, n);
    close_out();
  end
endmodule
`default_nettype wire
